// *** rtl/dco_operand_regs.sv ***
`timescale 1ns/100ps
`include "dco_defs.svh"

module dco_operand_regs #(
  parameter int PEL_BITS = 32
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // pixel request from the coprocessor sequencer
  input  wire logic                   pix_valid,
  input  wire logic [2:0]             pel_depth_code,
  input  wire logic [PEL_BITS-1:0]    dst_pel,
  input  wire logic [PEL_BITS-1:0]    src_pel,
  input  wire logic                   pattern_bit,
  input  dco_pkg::dco_sel_t           front_operand_select,
  input  dco_pkg::dco_sel_t           back_operand_select,
  input  wire logic                   mix_add,
  input  wire logic [PEL_BITS-1:0]    cmp_value,
  input  dco_pkg::dco_cmp_t           cmp_cond,
  // pixel answer
  output logic                        result_valid,
  output logic [PEL_BITS-1:0]         result_pel,
  output logic [PEL_BITS-1:0]         operand_pel,
  output logic                        update_inhibit,
  // operation geometry to the sequencer
  output logic [`DCO_DIM_BITS:0]      op_width_count,
  output logic [`DCO_DIM_BITS:0]      op_height_count,
  output logic [15:0]                 clip_origin_x_offset,
  output logic [15:0]                 clip_origin_y_offset,
  output logic [15:0]                 src_coord_x,
  output logic [15:0]                 src_coord_y,
  output logic [15:0]                 pattern_coord_x,
  output logic [15:0]                 pattern_coord_y,
  output logic [31:0]                 dst_coord_x_ext,
  output logic [31:0]                 dst_coord_y_ext
);

  logic [31:0]               plane_update_mask;
  logic [`DCO_CARRY_BITS-1:0] carry_break_mask;
  logic [31:0]               fixed_front_colour;
  logic [31:0]               fixed_back_colour;
  logic [15:0]               op_width_minus_one;
  logic [15:0]               op_height_minus_one;
  logic [15:0]               dst_coord_x;
  logic [15:0]               dst_coord_y;
  logic [31:0]               next_prdata;
  logic                      next_pslverr;
  logic                      wr_en;
  logic [PEL_BITS-1:0]       depth_mask;
  logic [PEL_BITS-1:0]       msb_onehot;
  logic [PEL_BITS-1:0]       eff_pm;
  logic [PEL_BITS-1:0]       eff_cm;
  logic [PEL_BITS-1:0]       sel_operand;
  logic [PEL_BITS-1:0]       a_in;
  logic [PEL_BITS-1:0]       b_in;
  logic [PEL_BITS-1:0]       sum;
  logic [PEL_BITS:0]         carry;
  logic [PEL_BITS-1:0]       next_result;
  logic [PEL_BITS-1:0]       cmp_masked;
  logic                      next_inhibit;

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // apb: zero wait states, read data and error prepared in the setup cycle
  assign wr_en = psel && penable && pwrite;

  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    // write-only registers answer zero so stale colours are never exposed
    if (hit(paddr, `DCO_IDX_PLANE_MASK) || hit(paddr, `DCO_IDX_CARRY_MASK) ||
        hit(paddr, `DCO_IDX_FRONT_COL) || hit(paddr, `DCO_IDX_BACK_COL) ||
        hit(paddr, `DCO_IDX_WIDTH_M1) || hit(paddr, `DCO_IDX_HEIGHT_M1) ||
        hit(paddr, `DCO_IDX_CLIP_X) || hit(paddr, `DCO_IDX_CLIP_Y))
      next_prdata = 32'h0000_0000;
    else if (hit(paddr, `DCO_IDX_SRC_X))
      next_prdata = {16'h0000, src_coord_x};
    else if (hit(paddr, `DCO_IDX_SRC_Y))
      next_prdata = {16'h0000, src_coord_y};
    else if (hit(paddr, `DCO_IDX_PAT_X))
      next_prdata = {16'h0000, pattern_coord_x};
    else if (hit(paddr, `DCO_IDX_PAT_Y))
      next_prdata = {16'h0000, pattern_coord_y};
    else if (hit(paddr, `DCO_IDX_DST_X))
      next_prdata = {16'h0000, dst_coord_x};
    else if (hit(paddr, `DCO_IDX_DST_Y))
      next_prdata = {16'h0000, dst_coord_y};
    else
      next_pslverr = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end
      else if (!psel)
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      plane_update_mask    <= `DCO_RST_WORD;
      carry_break_mask     <= `DCO_CARRY_BITS'(`DCO_RST_WORD);
      fixed_front_colour   <= `DCO_RST_WORD;
      fixed_back_colour    <= `DCO_RST_WORD;
      op_width_minus_one   <= `DCO_RST_HALF;
      op_height_minus_one  <= `DCO_RST_HALF;
      clip_origin_x_offset <= `DCO_RST_HALF;
      clip_origin_y_offset <= `DCO_RST_HALF;
      src_coord_x          <= `DCO_RST_HALF;
      src_coord_y          <= `DCO_RST_HALF;
      pattern_coord_x      <= `DCO_RST_HALF;
      pattern_coord_y      <= `DCO_RST_HALF;
      dst_coord_x          <= `DCO_RST_HALF;
      dst_coord_y          <= `DCO_RST_HALF;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `DCO_IDX_PLANE_MASK))
        plane_update_mask <= pwdata;
      else if (hit(paddr, `DCO_IDX_CARRY_MASK))
        carry_break_mask <= pwdata[`DCO_CARRY_BITS-1:0];
      else if (hit(paddr, `DCO_IDX_FRONT_COL))
        fixed_front_colour <= pwdata;
      else if (hit(paddr, `DCO_IDX_BACK_COL))
        fixed_back_colour <= pwdata;
      else if (hit(paddr, `DCO_IDX_WIDTH_M1))
        op_width_minus_one <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_HEIGHT_M1))
        op_height_minus_one <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_CLIP_X))
        clip_origin_x_offset <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_CLIP_Y))
        clip_origin_y_offset <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_SRC_X))
        src_coord_x <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_SRC_Y))
        src_coord_y <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_PAT_X))
        pattern_coord_x <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_PAT_Y))
        pattern_coord_y <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_DST_X))
        dst_coord_x <= pwdata[15:0];
      else if (hit(paddr, `DCO_IDX_DST_Y))
        dst_coord_y <= pwdata[15:0];
    end
  end

  // counts and extended destination coordinates presented to the sequencer, one cycle behind the registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_width_count  <= '0;
      op_height_count <= '0;
      dst_coord_x_ext <= 32'h0000_0000;
      dst_coord_y_ext <= 32'h0000_0000;
    end
    else
    begin
      // only twelve bits count; software keeps the value within range
      op_width_count  <= {1'b0, op_width_minus_one[`DCO_DIM_BITS-1:0]} + 13'h001;
      op_height_count <= {1'b0, op_height_minus_one[`DCO_DIM_BITS-1:0]} + 13'h001;
      dst_coord_x_ext <= {{16{dst_coord_x[15]}}, dst_coord_x};
      dst_coord_y_ext <= {{16{dst_coord_y[15]}}, dst_coord_y};
    end
  end

  // pixel depth: codes 0..5 give 1, 2, 4, 8, 16, 32 bits
  always_comb
  begin
    case (pel_depth_code)
      3'h0:    depth_mask = PEL_BITS'(32'h0000_0001);
      3'h1:    depth_mask = PEL_BITS'(32'h0000_0003);
      3'h2:    depth_mask = PEL_BITS'(32'h0000_000f);
      3'h3:    depth_mask = PEL_BITS'(32'h0000_00ff);
      3'h4:    depth_mask = PEL_BITS'(32'h0000_ffff);
      default: depth_mask = PEL_BITS'(32'hffff_ffff);
    endcase
  end

  assign msb_onehot = depth_mask ^ (depth_mask >> 1);
  assign eff_pm     = PEL_BITS'(plane_update_mask) & depth_mask;
  assign eff_cm     = PEL_BITS'({1'b0, carry_break_mask}) & depth_mask;

  // operand selection; reserved codes fall back to the fixed colour
  always_comb
  begin
    if (pattern_bit)
      sel_operand = (front_operand_select == dco_pkg::DCO_SEL_SOURCE) ?
                    src_pel : PEL_BITS'(fixed_front_colour);
    else
      sel_operand = (back_operand_select == dco_pkg::DCO_SEL_SOURCE) ?
                    src_pel : PEL_BITS'(fixed_back_colour);
  end

  // masked bits are zeroed so they cannot feed a carry into live bits
  assign a_in = dst_pel & eff_pm;
  assign b_in = sel_operand & eff_pm;

  assign carry[0] = 1'b0;
  for (genvar i = 0; i < PEL_BITS; i++)
  begin : g_chain
    assign sum[i] = a_in[i] ^ b_in[i] ^ carry[i];
    assign carry[i+1] = ((a_in[i] & b_in[i]) | (carry[i] & (a_in[i] | b_in[i])))
                        & eff_cm[i] & ~msb_onehot[i];
  end

  assign next_result = ((mix_add ? sum : b_in) & eff_pm) | (dst_pel & ~eff_pm);
  assign cmp_masked  = cmp_value & eff_pm;

  always_comb
  begin
    case (cmp_cond)
      dco_pkg::DCO_CMP_TRUE:  next_inhibit = 1'b1;
      dco_pkg::DCO_CMP_GT:    next_inhibit = a_in > cmp_masked;
      dco_pkg::DCO_CMP_EQ:    next_inhibit = a_in == cmp_masked;
      dco_pkg::DCO_CMP_LT:    next_inhibit = a_in < cmp_masked;
      dco_pkg::DCO_CMP_FALSE: next_inhibit = 1'b0;
      dco_pkg::DCO_CMP_GE:    next_inhibit = a_in >= cmp_masked;
      dco_pkg::DCO_CMP_GT2:   next_inhibit = a_in > cmp_masked;
      default:                next_inhibit = a_in <= cmp_masked;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_valid   <= 1'b0;
      result_pel     <= '0;
      operand_pel    <= '0;
      update_inhibit <= 1'b0;
    end
    else
    begin
      result_valid <= pix_valid;
      if (pix_valid)
      begin
        result_pel     <= next_result;
        operand_pel    <= sel_operand & depth_mask;
        update_inhibit <= next_inhibit;
      end
    end
  end

  // helper copies for the checks below
  logic [PEL_BITS-1:0] h_dst;
  logic [PEL_BITS-1:0] h_pm;
  logic [PEL_BITS-1:0] h_xor;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      h_dst <= '0;
      h_pm  <= '0;
      h_xor <= '0;
    end
    else
    begin
      h_dst <= dst_pel;
      h_pm  <= eff_pm;
      h_xor <= ((a_in ^ b_in) & eff_pm) | (dst_pel & ~eff_pm);
    end
  end

  a_plane_keep_bits: assert property (@(posedge pclk) disable iff (!presetn)
    result_valid |-> ((result_pel ^ h_dst) & ~h_pm) == '0)
    else $error("masked pixel bit changed");
  a_masked_compare: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && cmp_cond == dco_pkg::DCO_CMP_EQ && eff_pm == '0 |=> update_inhibit)
    else $error("masked bits affected compare");
  a_depth_high_bits: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && pel_depth_code == 3'h2 |=> result_pel[PEL_BITS-1:4] == h_dst[PEL_BITS-1:4])
    else $error("bits above depth changed");
  a_carry_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && mix_add && eff_cm == '0 |=> result_pel == h_xor)
    else $error("carry crossed a blocked position");
  a_msb_no_carry: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && mix_add && pel_depth_code == 3'h0 |=> result_pel == h_xor)
    else $error("carry left pixel msb");
  a_front_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && pattern_bit && front_operand_select == dco_pkg::DCO_SEL_FIXED
    |=> operand_pel == ($past(fixed_front_colour) & $past(depth_mask)))
    else $error("front colour not selected");
  a_back_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && !pattern_bit && back_operand_select == dco_pkg::DCO_SEL_FIXED
    |=> operand_pel == ($past(fixed_back_colour) & $past(depth_mask)))
    else $error("back colour not selected");
  a_front_source: assert property (@(posedge pclk) disable iff (!presetn)
    pix_valid && pattern_bit && front_operand_select == dco_pkg::DCO_SEL_SOURCE
    |=> operand_pel == ($past(src_pel) & $past(depth_mask)))
    else $error("source map not selected");
  // the count follows the register by one edge, so look two edges after the write
  a_width_count: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `DCO_IDX_WIDTH_M1) && pwdata[15:12] == 4'h0
    |=> ##1 op_width_count == {1'b0, $past(pwdata[11:0], 2)} + 13'h001)
    else $error("width count wrong");
  // the first edge after reset still shows the reset value, so it is skipped
  a_height_count: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> op_height_count == {1'b0, $past(op_height_minus_one[11:0])} + 13'h001)
    else $error("height count wrong");
  a_wo_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, `DCO_IDX_FRONT_COL) |=> prdata == 32'h0)
    else $error("write-only register read back");
  a_src_readback: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, `DCO_IDX_SRC_X)
    |=> prdata == {16'h0000, $past(src_coord_x)})
    else $error("source x readback wrong");
  a_dst_sign_ext: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, `DCO_IDX_DST_X) |=> ##1 dst_coord_x_ext[31:15] == {17{dst_coord_x[15]}})
    else $error("destination x not sign extended");

  c_add_mix: cover property (@(posedge pclk) pix_valid && mix_add && eff_cm != '0);
  c_src_operand: cover property (@(posedge pclk) pix_valid && !pattern_bit &&
    back_operand_select == dco_pkg::DCO_SEL_SOURCE);
  c_inhibit: cover property (@(posedge pclk) result_valid && update_inhibit);
  c_bad_addr: cover property (@(posedge pclk) psel && penable && pslverr);
  c_narrow_add: cover property (@(posedge pclk) pix_valid && mix_add && pel_depth_code == 3'h0);

endmodule : dco_operand_regs

// *** include/dco_defs.svh ***
`ifndef DCO_DEFS_SVH
`define DCO_DEFS_SVH

// register indices; byte address is four times the index
`define DCO_IDX_PLANE_MASK  10'h050
`define DCO_IDX_CARRY_MASK  10'h054
`define DCO_IDX_FRONT_COL   10'h058
`define DCO_IDX_BACK_COL    10'h05c
`define DCO_IDX_WIDTH_M1    10'h060
`define DCO_IDX_HEIGHT_M1   10'h062
`define DCO_IDX_CLIP_X      10'h06c
`define DCO_IDX_CLIP_Y      10'h06e
`define DCO_IDX_SRC_X       10'h070
`define DCO_IDX_SRC_Y       10'h072
`define DCO_IDX_PAT_X       10'h074
`define DCO_IDX_PAT_Y       10'h076
`define DCO_IDX_DST_X       10'h078
`define DCO_IDX_DST_Y       10'h07a

// field layout and reset values
`define DCO_CARRY_BITS      31
`define DCO_DIM_BITS        12
`define DCO_RST_WORD        32'h0000_0000
`define DCO_RST_HALF        16'h0000

`endif

// *** include/dco_pkg.sv ***
package dco_pkg;

  // operand source selection codes
  typedef enum logic [1:0] {
    DCO_SEL_FIXED  = 2'h0,
    DCO_SEL_RSVD1  = 2'h1,
    DCO_SEL_SOURCE = 2'h2,
    DCO_SEL_RSVD3  = 2'h3
  } dco_sel_t;

  // destination colour compare conditions
  typedef enum logic [2:0] {
    DCO_CMP_TRUE  = 3'h0,
    DCO_CMP_GT    = 3'h1,
    DCO_CMP_EQ    = 3'h2,
    DCO_CMP_LT    = 3'h3,
    DCO_CMP_FALSE = 3'h4,
    DCO_CMP_GE    = 3'h5,
    DCO_CMP_GT2   = 3'h6,
    DCO_CMP_LE    = 3'h7
  } dco_cmp_t;

endpackage : dco_pkg

// *** dv/dco_operand_regs_bench.sv ***
`timescale 1ns/100ps
`include "dco_defs.svh"

module dco_operand_regs_bench;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic               pready;
  logic [31:0]        prdata;
  logic               pslverr;
  logic               pix_valid;
  logic [2:0]         pel_depth_code;
  logic [31:0]        dst_pel;
  logic [31:0]        src_pel;
  logic               pattern_bit;
  dco_pkg::dco_sel_t  fsel;
  dco_pkg::dco_sel_t  bsel;
  logic               mix_add;
  logic [31:0]        cmp_value;
  dco_pkg::dco_cmp_t  cmp_cond;
  logic               result_valid;
  logic [31:0]        result_pel;
  logic [31:0]        operand_pel;
  logic               update_inhibit;
  logic [12:0]        wcnt;
  logic [12:0]        hcnt;
  logic [15:0]        clip_x;
  logic [15:0]        clip_y;
  logic [15:0]        src_x;
  logic [15:0]        src_y;
  logic [15:0]        pat_x;
  logic [15:0]        pat_y;
  logic [31:0]        dst_x;
  logic [31:0]        dst_y;
  int                 failures;
  int                 cmp_count;
  int                 cycles;

  dco_operand_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pix_valid(pix_valid), .pel_depth_code(pel_depth_code), .dst_pel(dst_pel),
    .src_pel(src_pel), .pattern_bit(pattern_bit), .front_operand_select(fsel),
    .back_operand_select(bsel), .mix_add(mix_add), .cmp_value(cmp_value),
    .cmp_cond(cmp_cond), .result_valid(result_valid), .result_pel(result_pel),
    .operand_pel(operand_pel), .update_inhibit(update_inhibit), .op_width_count(wcnt),
    .op_height_count(hcnt), .clip_origin_x_offset(clip_x), .clip_origin_y_offset(clip_y),
    .src_coord_x(src_x), .src_coord_y(src_y), .pattern_coord_x(pat_x),
    .pattern_coord_y(pat_y), .dst_coord_x_ext(dst_x), .dst_coord_y_ext(dst_y)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // data and response are taken at the edge that sees pready, before its updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no fixed wait is assumed; only the bench ceiling ends a stuck transfer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, {idx, 2'b00}, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, {idx, 2'b00}, 32'h0000_0000, rd, err);
    chk("prdata", rd, exp);
    chk("pslverr", {31'h0, err}, 32'h0000_0000);
  endtask : rd_chk

  task automatic pix(input logic [31:0] dst, output logic [31:0] res, output logic [31:0] op,
                     output logic inh);
    @(posedge pclk);
    pix_valid <= 1'b1;
    dst_pel <= dst;
    @(posedge pclk);
    pix_valid <= 1'b0;
    #1;
    chk("result_valid", {31'h0, result_valid}, 32'h0000_0001);
    res = result_pel;
    op = operand_pel;
    inh = update_inhibit;
    @(posedge pclk);
    #1;
    chk("result_valid_drop", {31'h0, result_valid}, 32'h0000_0000);
    // return on an edge so the caller's next inputs change at the clock
    @(posedge pclk);
  endtask : pix

  task automatic t_coords;
    logic [9:0]  idx [6];
    logic [31:0] val [6];
    idx = '{`DCO_IDX_SRC_X, `DCO_IDX_SRC_Y, `DCO_IDX_PAT_X, `DCO_IDX_PAT_Y,
            `DCO_IDX_DST_X, `DCO_IDX_DST_Y};
    val = '{32'h0000_0fff, 32'h0000_0000, 32'h0000_0123, 32'h0000_0abc,
            32'h0000_f800, 32'h0000_17ff};
    // upper write bits must not stick in a 16-bit register
    for (int i = 0; i < 6; i++)
      wr(idx[i], val[i] | 32'hdead_0000);
    for (int i = 0; i < 6; i++)
      rd_chk(idx[i], val[i]);
    @(posedge pclk);
    #1;
    chk("src_x", {16'h0, src_x}, 32'h0000_0fff);
    chk("src_y", {16'h0, src_y}, 32'h0000_0000);
    chk("pat_x", {16'h0, pat_x}, 32'h0000_0123);
    chk("pat_y", {16'h0, pat_y}, 32'h0000_0abc);
    chk("dst_x", dst_x, 32'hffff_f800);
    chk("dst_y", dst_y, 32'h0000_17ff);
  endtask : t_coords

  task automatic t_refused;
    logic [31:0] rd;
    logic        err;
    logic [9:0]  wo [8];
    wo = '{`DCO_IDX_PLANE_MASK, `DCO_IDX_CARRY_MASK, `DCO_IDX_FRONT_COL, `DCO_IDX_BACK_COL,
           `DCO_IDX_WIDTH_M1, `DCO_IDX_HEIGHT_M1, `DCO_IDX_CLIP_X, `DCO_IDX_CLIP_Y};
    for (int i = 0; i < 8; i++)
    begin
      wr(wo[i], 32'h0000_0a5a);
      rd_chk(wo[i], 32'h0000_0000);
    end
    apb(1'b0, 12'h004, 32'h0000_0000, rd, err);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped_data", rd, 32'h0000_0000);
    // misaligned write two bytes into the destination x word is refused
    apb(1'b1, 12'h1e2, 32'h0000_0555, rd, err);
    chk("misaligned_err", {31'h0, err}, 32'h0000_0001);
    rd_chk(`DCO_IDX_DST_X, 32'h0000_f800);
  endtask : t_refused

  task automatic t_dims;
    wr(`DCO_IDX_WIDTH_M1, 32'h0000_0009);
    wr(`DCO_IDX_HEIGHT_M1, 32'h0000_0fff);
    wr(`DCO_IDX_CLIP_X, 32'h0000_0fff);
    wr(`DCO_IDX_CLIP_Y, 32'h0000_0800);
    @(posedge pclk);
    #1;
    chk("width_count", {19'h0, wcnt}, 32'h0000_000a);
    chk("height_count", {19'h0, hcnt}, 32'h0000_1000);
    chk("clip_x", {16'h0, clip_x}, 32'h0000_0fff);
    chk("clip_y", {16'h0, clip_y}, 32'h0000_0800);
    wr(`DCO_IDX_WIDTH_M1, 32'h0000_0000);
    @(posedge pclk);
    #1;
    chk("width_count_min", {19'h0, wcnt}, 32'h0000_0001);
  endtask : t_dims

  task automatic t_select;
    logic [31:0] res;
    logic [31:0] op;
    logic        inh;
    logic [31:0] e;
    @(posedge pclk);
    pel_depth_code <= 3'h3;
    mix_add <= 1'b0;
    src_pel <= 32'h5566_7788;
    wr(`DCO_IDX_PLANE_MASK, 32'hffff_ffff);
    wr(`DCO_IDX_FRONT_COL, 32'habcd_ef12);
    wr(`DCO_IDX_BACK_COL, 32'h1122_3344);
    for (int c = 0; c < 8; c++)
    begin
      pattern_bit <= c[2];
      fsel <= dco_pkg::dco_sel_t'(c[1:0]);
      bsel <= dco_pkg::dco_sel_t'(c[1:0]);
      e = (c[1:0] == 2'h2) ? 32'h0000_0088 : (c[2] ? 32'h0000_0012 : 32'h0000_0044);
      pix(32'ha5a5_a5a5, res, op, inh);
      chk("operand_pel", op, e);
      chk("result_pel", res, 32'ha5a5_a500 | e);
    end
    pattern_bit <= 1'b1;
    fsel <= dco_pkg::DCO_SEL_FIXED;
    wr(`DCO_IDX_PLANE_MASK, 32'h0000_000f);
    pix(32'ha5a5_a5a5, res, op, inh);
    chk("masked_result", res, 32'ha5a5_a5a2);
  endtask : t_select

  task automatic t_carry;
    logic [31:0] res;
    logic [31:0] op;
    logic        inh;
    logic [31:0] tab [8][5];
    logic [2:0]  dep [8];
    // plane mask, carry mask, destination, foreground colour, expected result
    tab = '{'{32'h0000_00ff, 32'h0000_00ff, 32'h0000_000f, 32'h0000_0001, 32'h0000_0010},
            '{32'h0000_00ff, 32'h0000_00f7, 32'h0000_000f, 32'h0000_0001, 32'h0000_0000},
            '{32'h0000_00ff, 32'h0000_00ff, 32'h0000_01ff, 32'h0000_0001, 32'h0000_0100},
            '{32'h0000_00fe, 32'h0000_00ff, 32'h0000_000f, 32'h0000_0001, 32'h0000_000f},
            '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0001, 32'h0000_0000},
            '{32'h0000_00ff, 32'h0000_0000, 32'h0000_000f, 32'h0000_0001, 32'h0000_000e},
            '{32'h0000_0001, 32'h0000_0001, 32'h0000_0003, 32'h0000_0001, 32'h0000_0002},
            '{32'h0000_00ff, 32'h0000_00ff, 32'h0000_0f0f, 32'h0000_0001, 32'h0000_0f00}};
    // pixel depth code for each row: 8, 32, 1 and 4 bits per pixel
    dep = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h5, 3'h3, 3'h0, 3'h2};
    mix_add <= 1'b1;
    pattern_bit <= 1'b1;
    fsel <= dco_pkg::DCO_SEL_FIXED;
    for (int i = 0; i < 8; i++)
    begin
      pel_depth_code <= dep[i];
      wr(`DCO_IDX_PLANE_MASK, tab[i][0]);
      wr(`DCO_IDX_CARRY_MASK, tab[i][1]);
      wr(`DCO_IDX_FRONT_COL, tab[i][3]);
      pix(tab[i][2], res, op, inh);
      chk("add_result", res, tab[i][4]);
    end
  endtask : t_carry

  task automatic t_compare;
    logic [31:0] res;
    logic [31:0] op;
    logic        inh;
    logic [7:0]  exp_inh;
    exp_inh = 8'h63;
    pel_depth_code <= 3'h3;
    mix_add <= 1'b0;
    cmp_value <= 32'h0000_0004;
    wr(`DCO_IDX_PLANE_MASK, 32'h0000_00ff);
    for (int c = 0; c < 8; c++)
    begin
      cmp_cond <= dco_pkg::dco_cmp_t'(c[2:0]);
      pix(32'h0000_0005, res, op, inh);
      chk("update_inhibit", {31'h0, inh}, {31'h0, exp_inh[c]});
    end
    // masked low bit and bits above the depth take no part in the compare
    cmp_cond <= dco_pkg::DCO_CMP_EQ;
    wr(`DCO_IDX_PLANE_MASK, 32'h0000_00fe);
    pix(32'hff00_0005, res, op, inh);
    chk("masked_compare", {31'h0, inh}, 32'h0000_0001);
    // with every bit masked the compare sees zero against zero and nothing changes
    wr(`DCO_IDX_PLANE_MASK, 32'h0000_0000);
    pix(32'h0000_0077, res, op, inh);
    chk("zero_mask_compare", {31'h0, inh}, 32'h0000_0001);
    chk("zero_mask_result", res, 32'h0000_0077);
  endtask : t_compare

  initial
  begin
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pix_valid = 1'b0;
    pel_depth_code = 3'h3;
    dst_pel = 32'h0000_0000;
    src_pel = 32'h0000_0000;
    pattern_bit = 1'b1;
    fsel = dco_pkg::DCO_SEL_FIXED;
    bsel = dco_pkg::DCO_SEL_FIXED;
    mix_add = 1'b0;
    cmp_value = 32'h0000_0000;
    cmp_cond = dco_pkg::DCO_CMP_FALSE;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_coords();
    t_refused();
    t_dims();
    t_select();
    t_carry();
    t_compare();
    end_sim();
  end
endmodule : dco_operand_regs_bench
